// File: verilog/fss_pkg.sv
// Package for the fast serial channel: register map, bit positions, reset values, timing.
// Assumes a 50 MHz system clock and an APB slave port with 16-bit byte addresses.
package fss_pkg;
  localparam logic [15:0] OFF_CONTROL = 16'h0C00;
  localparam logic [15:0] OFF_FLAGS = 16'h0C04;
  localparam logic [15:0] OFF_STICKY = 16'h0C08;
  localparam logic [15:0] OFF_CLR_EN = 16'h0C0C;
  localparam logic [15:0] OFF_IRQ_EN = 16'h0C10;
  localparam logic [15:0] OFF_IRQ_REQ = 16'h0C14;
  localparam logic [15:0] OFF_TX_DATA = 16'h0C18;
  localparam logic [15:0] OFF_RX_DATA = 16'h0C1C;

  localparam int CTL_UNIT_RX = 0;
  localparam int CTL_SEQ_RX = 1;
  localparam int CTL_UNIT16 = 5;
  localparam int CTL_DMA_RX = 8;
  localparam int CTL_DMA_TX = 9;
  localparam logic [15:0] CTL_WMASK = 16'h0323;
  localparam logic [15:0] CONTROL_RST = 16'h0000;

  localparam int NUM_SRC = 4;
  localparam int SRC_TX_SHIFT = 3;
  localparam int SRC_RX_SHIFT = 2;
  localparam int SRC_TX_BUF = 1;
  localparam int SRC_RX_READ = 0;
  localparam logic [3:0] FLAGS_RST = 4'hA;
  localparam logic [3:0] MASK_RST = 4'h0;

  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] UNIT8_BITS = 5'h08;
  localparam logic [4:0] UNIT16_BITS = 5'h10;

  typedef enum logic [2:0] {
    FSS_IDLE = 3'b001,
    FSS_LOW = 3'b010,
    FSS_HIGH = 3'b100
  } fss_shift_state_t;
endpackage

// File: verilog/fss_irq_cell.sv
// One interrupt source: edge-set sticky status, gated clear, masked request, DMA one-shot.
// Assumes synchronous raw flag and single-cycle clear strobe on the system clock.
`timescale 1ns/10ps
`default_nettype none
module fss_irq_cell import fss_pkg::*; #(
  parameter logic RAW_RST = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic raw_in,
  input wire logic dma_en_in,
  input wire logic clr_in,
  input wire logic clr_en_in,
  input wire logic irq_en_in,
  output logic sticky_out,
  output logic request_out,
  output logic oneshot_out
);
  logic raw_prev_reg;
  logic rise;

  // Seeded with the flag's reset level so release gives no false edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raw_prev_reg <= RAW_RST;
    end else begin
      raw_prev_reg <= raw_in;
    end
  end

  assign rise = raw_in & ~raw_prev_reg;

  // Set beats clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sticky_out <= 1'b0;
    end else if (rise && !dma_en_in) begin
      sticky_out <= 1'b1;
    end else if (clr_in && clr_en_in) begin
      sticky_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      request_out <= 1'b0;
    end else begin
      request_out <= sticky_out & irq_en_in;
    end
  end

  // No sticky bit in DMA use, so the DMA never needs to clear one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oneshot_out <= 1'b0;
    end else begin
      oneshot_out <= rise & dma_en_in;
    end
  end
endmodule
`default_nettype wire

// File: verilog/fss_shift.sv
// Unit shifter: drives the serial clock by division, shifts out MSB first, samples in.
// Assumes a synchronised data input and a start pulse only while idle.
`timescale 1ns/10ps
`default_nettype none
module fss_shift import fss_pkg::*; #(
  parameter int HALF = SCLK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic unit16_in,
  input wire logic [15:0] data_in,
  input wire logic miso_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rx_data_out,
  output logic sclk_out,
  output logic mosi_out
);
  fss_shift_state_t state_reg;
  logic [7:0] div_reg;
  logic [4:0] bits_reg;
  logic [15:0] sh_reg;
  logic unit16_reg;
  logic half_done;

  if (HALF < 1 || HALF > 255) begin : g_chk
    $error("fss_shift: HALF out of range");
  end

  assign half_done = (div_reg == 8'(HALF - 1));
  assign busy_out = (state_reg != FSS_IDLE);
  assign rx_data_out = unit16_reg ? sh_reg : {8'h00, sh_reg[7:0]};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= FSS_IDLE;
      div_reg <= 8'h00;
      bits_reg <= 5'h00;
      sh_reg <= 16'h0000;
      unit16_reg <= 1'b0;
      sclk_out <= 1'b0;
      mosi_out <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_reg)
        FSS_IDLE: begin
          if (start_in) begin
            // Size latched here so a later control write cannot corrupt a unit
            unit16_reg <= unit16_in;
            sh_reg <= unit16_in ? data_in : {data_in[7:0], 8'h00};
            bits_reg <= unit16_in ? UNIT16_BITS : UNIT8_BITS;
            mosi_out <= unit16_in ? data_in[15] : data_in[7];
            div_reg <= 8'h00;
            state_reg <= FSS_LOW;
          end
        end
        FSS_LOW: begin
          if (half_done) begin
            div_reg <= 8'h00;
            sclk_out <= 1'b1;
            sh_reg <= {sh_reg[14:0], miso_in};
            state_reg <= FSS_HIGH;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        FSS_HIGH: begin
          if (half_done) begin
            div_reg <= 8'h00;
            sclk_out <= 1'b0;
            if (bits_reg == 5'h01) begin
              done_out <= 1'b1;
              mosi_out <= 1'b1;
              state_reg <= FSS_IDLE;
            end else begin
              bits_reg <= bits_reg - 5'h01;
              mosi_out <= sh_reg[15];
              state_reg <= FSS_LOW;
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= FSS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verilog/fss_top.sv
// Fast serial channel core: APB registers, transmit and receive buffering, status and requests.
// Assumes an APB master on clk_in and an external serial peripheral clocked by sclk_out.
`timescale 1ns/10ps
`default_nettype none
module fss_top import fss_pkg::*; #(
  parameter int HALF = SCLK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic [3:0] irq_request_out,
  output logic dma_tx_req_out,
  output logic dma_rx_req_out
);
  logic rst_s1_reg;
  logic rst_b;
  logic miso_s1_reg;
  logic miso_s2_reg;
  logic miso_s3_reg;
  logic miso_reg;
  logic [15:0] control_reg;
  logic [3:0] clr_en_reg;
  logic [3:0] irq_en_reg;
  logic [15:0] tx_buf_reg;
  logic tx_buf_valid_reg;
  logic tx_active_reg;
  logic op_rx_reg;
  logic [15:0] rx_shift_reg;
  logic rx_shift_valid_reg;
  logic [15:0] rx_read_reg;
  logic rx_read_valid_reg;
  logic unit_pending_reg;
  logic [31:0] rd_next;
  logic addr_ok;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic eng_busy;
  logic eng_done;
  logic [15:0] eng_rx;
  logic eng_start;
  logic tx_go;
  logic rx_go;
  logic rx_allow;
  logic rx_move;
  logic [3:0] flags;
  logic [3:0] sticky;
  logic [3:0] dma_pulse;
  logic unit_en;
  logic seq_en;
  logic miso_sync;
  logic wr_ctl;
  logic wr_sticky;
  logic wr_clr_en;
  logic wr_irq_en;
  logic wr_tx;
  logic rd_rx;
  logic [3:0] dma_en;
  logic [3:0] sticky_clr;

  // Pin sync lags four edges; a shorter half period samples the previous bit
  if (HALF < 4 || HALF > 255) begin : g_half_chk
    $error("fss_top: HALF out of range");
  end

  // Reset release through two stages
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_reg <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_b <= rst_s1_reg;
    end
  end

  // Data pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      miso_s1_reg <= 1'b1;
      miso_s2_reg <= 1'b1;
      miso_s3_reg <= 1'b1;
      miso_reg <= 1'b1;
    end else begin
      miso_s1_reg <= miso_in;
      miso_s2_reg <= miso_s1_reg;
      miso_s3_reg <= miso_s2_reg;
      miso_reg <= miso_sync;
    end
  end

  // Used at once: the shifter sees a new bit four edges after the pin moves
  assign miso_sync = (miso_s2_reg == miso_s3_reg) ? miso_s3_reg : miso_reg;

  // APB decode: one wait state, write and read take effect at the pready edge
  assign acc = psel_in & penable_in & pready_out;
  assign acc_wr = acc & pwrite_in & addr_ok;
  assign acc_rd = acc & ~pwrite_in & addr_ok;
  assign unit_en = control_reg[CTL_UNIT_RX];
  assign seq_en = control_reg[CTL_SEQ_RX];
  // One strobe per writable register plus the receive data read, taken at the pready edge
  assign wr_ctl = acc_wr & (paddr_in == OFF_CONTROL);
  assign wr_sticky = acc_wr & (paddr_in == OFF_STICKY);
  assign wr_clr_en = acc_wr & (paddr_in == OFF_CLR_EN);
  assign wr_irq_en = acc_wr & (paddr_in == OFF_IRQ_EN);
  assign wr_tx = acc_wr & (paddr_in == OFF_TX_DATA);
  assign rd_rx = acc_rd & (paddr_in == OFF_RX_DATA);
  assign sticky_clr = wr_sticky ? pwdata_in[3:0] : 4'h0;

  always_comb begin
    addr_ok = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr_in)
      OFF_CONTROL: rd_next = {16'h0000, control_reg};
      OFF_FLAGS: rd_next = {28'h000_0000, flags};
      OFF_STICKY: rd_next = {28'h000_0000, sticky};
      OFF_CLR_EN: rd_next = {28'h000_0000, clr_en_reg};
      OFF_IRQ_EN: rd_next = {28'h000_0000, irq_en_reg};
      OFF_IRQ_REQ: rd_next = {28'h000_0000, irq_request_out};
      OFF_TX_DATA: rd_next = {16'h0000, tx_buf_reg};
      OFF_RX_DATA: rd_next = {16'h0000, rx_read_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        prdata_out <= rd_next;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= CONTROL_RST;
    end else if (wr_ctl) begin
      control_reg <= pwdata_in[15:0] & CTL_WMASK;
      // Size held while a unit is on the wire
      if (eng_busy) begin
        control_reg[CTL_UNIT16] <= control_reg[CTL_UNIT16];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      clr_en_reg <= MASK_RST;
      irq_en_reg <= MASK_RST;
    end else begin
      if (wr_clr_en) begin
        clr_en_reg <= pwdata_in[3:0];
      end
      if (wr_irq_en) begin
        irq_en_reg <= pwdata_in[3:0];
      end
    end
  end

  // Engine arbitration: pending transmit data first, reception otherwise
  assign tx_go = ~eng_busy & tx_buf_valid_reg;
  // Sequential: shift and read stages form the double buffer
  // Unit: one unit at a time, waits for the read stage to drain
  assign rx_allow = seq_en ? ~rx_shift_valid_reg
                           : (unit_en & unit_pending_reg & ~rx_shift_valid_reg
                              & ~rx_read_valid_reg);
  // Not in the done cycle: the finished unit has not yet filled the shift stage
  assign rx_go = ~eng_busy & ~eng_done & ~tx_buf_valid_reg & rx_allow;
  assign eng_start = tx_go | rx_go;
  assign rx_move = rx_shift_valid_reg & ~rx_read_valid_reg;

  // Writes while the buffer is full are dropped; software paces by the flags
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_reg <= 16'h0000;
      tx_buf_valid_reg <= 1'b0;
    end else if (tx_go) begin
      tx_buf_valid_reg <= 1'b0;
    end else if (wr_tx && !tx_buf_valid_reg) begin
      tx_buf_reg <= pwdata_in[15:0];
      tx_buf_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      tx_active_reg <= 1'b0;
      op_rx_reg <= 1'b0;
    end else if (eng_start) begin
      tx_active_reg <= tx_go;
      op_rx_reg <= rx_go;
    end else if (eng_done) begin
      tx_active_reg <= 1'b0;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      unit_pending_reg <= 1'b0;
    end else if (wr_ctl && pwdata_in[CTL_UNIT_RX]) begin
      unit_pending_reg <= 1'b1;
    end else if (rd_rx && unit_en) begin
      unit_pending_reg <= 1'b1;
    end else if (rx_go) begin
      unit_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rx_shift_reg <= 16'h0000;
      rx_shift_valid_reg <= 1'b0;
    end else if (eng_done && op_rx_reg) begin
      rx_shift_reg <= eng_rx;
      rx_shift_valid_reg <= 1'b1;
    end else if (rx_move) begin
      rx_shift_valid_reg <= 1'b0;
    end
  end

  // Move into the read stage wins over a read of an already empty stage
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rx_read_reg <= 16'h0000;
      rx_read_valid_reg <= 1'b0;
    end else if (rx_move) begin
      rx_read_reg <= rx_shift_reg;
      rx_read_valid_reg <= 1'b1;
    end else if (rd_rx) begin
      rx_read_valid_reg <= 1'b0;
    end
  end

  // Raw flags straight from the internal conditions
  assign flags[SRC_TX_SHIFT] = ~tx_active_reg;
  assign flags[SRC_RX_SHIFT] = rx_shift_valid_reg;
  assign flags[SRC_TX_BUF] = ~tx_buf_valid_reg;
  assign flags[SRC_RX_READ] = rx_read_valid_reg;

  fss_shift #(
    .HALF(HALF)
  ) u_shift (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .start_in(eng_start),
    .unit16_in(control_reg[CTL_UNIT16]),
    .data_in(tx_go ? tx_buf_reg : 16'hFFFF),
    .miso_in(miso_sync),
    .busy_out(eng_busy),
    .done_out(eng_done),
    .rx_data_out(eng_rx),
    .sclk_out(sclk_out),
    .mosi_out(mosi_out)
  );

  // Only the two buffer sources can feed the DMA
  always_comb begin
    dma_en = 4'h0;
    dma_en[SRC_TX_BUF] = control_reg[CTL_DMA_TX];
    dma_en[SRC_RX_READ] = control_reg[CTL_DMA_RX];
  end

  // One cell per source, each seeded with its own flag's reset level
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    fss_irq_cell #(
      .RAW_RST(FLAGS_RST[i])
    ) u_cell (
      .clk_in(clk_in),
      .rst_b_in(rst_b),
      .raw_in(flags[i]),
      .dma_en_in(dma_en[i]),
      .clr_in(sticky_clr[i]),
      .clr_en_in(clr_en_reg[i]),
      .irq_en_in(irq_en_reg[i]),
      .sticky_out(sticky[i]),
      .request_out(irq_request_out[i]),
      .oneshot_out(dma_pulse[i])
    );
  end

  assign dma_tx_req_out = dma_pulse[SRC_TX_BUF];
  assign dma_rx_req_out = dma_pulse[SRC_RX_READ];
endmodule
`default_nettype wire

// File: tb/fss_top_assertions.sv
// Checker for the fast serial channel top: APB timing, status reads, DMA pulses, serial pins.
// Assumes it is bound to fss_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module fss_checker import fss_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic miso_in,
  input wire logic sclk_out,
  input wire logic mosi_out,
  input wire logic [3:0] irq_request_out,
  input wire logic dma_tx_req_out,
  input wire logic dma_rx_req_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic mapped;
  assign mapped = paddr_in inside {OFF_CONTROL, OFF_FLAGS, OFF_STICKY, OFF_CLR_EN,
    OFF_IRQ_EN, OFF_IRQ_REQ, OFF_TX_DATA, OFF_RX_DATA};
  a_ready_one_wait: assert property (psel_in && $rose(penable_in)
    |-> !pready_out ##1 pready_out) else $error("pready not after one wait state");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_unmapped_err: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("error response wrong for address");
  a_flags_upper: assert property (pready_out && !pwrite_in && paddr_in == OFF_FLAGS
    |-> prdata_out[31:4] == 28'h000_0000) else $error("flag word upper bits set");
  a_dma_tx_shot: assert property (dma_tx_req_out |=> !dma_tx_req_out)
    else $error("tx DMA trigger not one cycle");
  a_dma_rx_shot: assert property ($rose(dma_rx_req_out) |=> !dma_rx_req_out [*2])
    else $error("rx DMA trigger not one cycle");
  a_mosi_on_low: assert property ($changed(mosi_out) |-> !sclk_out)
    else $error("data line moved while serial clock high");
  c_dma_tx: cover property (dma_tx_req_out);
  c_slverr: cover property (pready_out && pslverr_out);
  c_sclk: cover property ($rose(sclk_out));
  c_irq: cover property (irq_request_out != 4'h0);
endmodule
bind fss_top fss_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .miso_in(miso_in), .sclk_out(sclk_out), .mosi_out(mosi_out),
  .irq_request_out(irq_request_out), .dma_tx_req_out(dma_tx_req_out),
  .dma_rx_req_out(dma_rx_req_out));
`default_nettype wire

// File: tb/fss_periph.sv
// Serial peripheral model: captures the data line on clock rise, answers a rotating pattern.
// Assumes the channel drives the serial clock, idle low, MSB first.
`timescale 1ns/10ps
`default_nettype none
module fss_periph #(
  parameter logic [7:0] PATTERN = 8'hA5
) (
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out
);
  logic [7:0] resp_reg = PATTERN;
  logic [31:0] got_reg = 32'h0000_0000;
  int nbits = 0;
  // Rise is mid-bit, the safe sample point
  always @(posedge sclk_in) begin
    got_reg <= {got_reg[30:0], mosi_in};
    nbits <= nbits + 1;
  end
  // No select line, so the answer always drives; a full unit rotates back to the pattern
  always @(negedge sclk_in) begin
    resp_reg <= {resp_reg[6:0], resp_reg[7]};
  end
  assign miso_out = resp_reg[7];
endmodule
`default_nettype wire

// File: tb/fss_top_bench.sv
// Self-checking bench for the fast serial channel top, APB master and serial peripheral model.
// Assumes fss_pkg, fss_top, the checker and fss_periph are compiled first.
`timescale 1ns/10ps
`default_nettype none
module fss_top_bench import fss_pkg::*; ();
  localparam logic [7:0] PAT = 8'hA5;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv_err, miso, sclk, mosi, dtx, drx, u;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rnd;
  logic [3:0] irq;
  logic pready, pslverr;
  int n_errors = 0, n_compared = 0, n_dtx = 0, n_drx = 0;
  always #10 clk_in = ~clk_in;
  fss_top #(.HALF(4)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .miso_in(miso),
    .sclk_out(sclk), .mosi_out(mosi), .irq_request_out(irq), .dma_tx_req_out(dtx),
    .dma_rx_req_out(drx));
  fss_periph #(.PATTERN(PAT)) u_per (.sclk_in(sclk), .mosi_in(mosi), .miso_out(miso));
  always @(posedge clk_in) begin
    if (dtx === 1'b1) n_dtx++;
    if (drx === 1'b1) n_drx++;
  end
  function logic [31:0] exp_tx(input logic [31:0] d, input logic u16);
    return u16 ? {16'h0000, d[15:0]} : {24'h00_0000, d[7:0]};
  endfunction
  function logic [31:0] exp_rx(input logic u16);
    return u16 ? {16'h0000, PAT, PAT} : {24'h00_0000, PAT};
  endfunction
  task close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 32'h1, 32'h0);
      close_out();
    end
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task rd(input string what, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask
  // Polls the flag word; a flag that never arrives ends the run
  task wait_flags(input logic [3:0] mask, input logic [3:0] val);
    logic [31:0] q;
    int i;
    for (i = 0; i < 100; i++) begin
      apb(1'b0, OFF_FLAGS, 32'h0000_0000, q);
      if ((q[3:0] & mask) === val) break;
    end
    chk("flag wait", {28'h000_0000, val}, {28'h000_0000, q[3:0] & mask});
    if (i == 100) close_out();
  endtask
  task tx_words(input logic u16, input logic [31:0] d1, input logic [31:0] d2, input int n);
    int base, w, i;
    logic [31:0] e, m;
    base = u_per.nbits;
    w = u16 ? 16 : 8;
    wr(OFF_TX_DATA, d1);
    if (n == 2) wr(OFF_TX_DATA, d2);
    e = (n == 2) ? ((exp_tx(d1, u16) << w) | exp_tx(d2, u16)) : exp_tx(d1, u16);
    m = (w * n == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (w * n)) - 32'h0000_0001);
    for (i = 0; i < 3000 && u_per.nbits < base + w * n; i++) @(posedge clk_in);
    if (u_per.nbits < base + w * n) begin
      chk("serial bits", base + w * n, u_per.nbits);
      close_out();
    end
    wait_flags(4'hA, 4'hA);
    chk("serial out", e, u_per.got_reg & m);
  endtask
  initial begin
    void'($urandom(32'h3476_8263));
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd("flags", OFF_FLAGS, 32'h0000_000A);
    rd("sticky", OFF_STICKY, 32'h0000_0000);
    rd("request", OFF_IRQ_REQ, 32'h0000_0000);
    rd("unmapped", 16'h0CFC, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, slv_err});
    wr(OFF_IRQ_EN, 32'h0000_000F);
    wr(OFF_CLR_EN, 32'h0000_0000);
    tx_words(1'b0, 32'h0000_00C3, 32'h0000_0000, 1);
    rd("sticky", OFF_STICKY, 32'h0000_000A);
    chk("irq pins", 32'h0000_000A, {28'h000_0000, irq});
    rd("request", OFF_IRQ_REQ, 32'h0000_000A);
    wr(OFF_STICKY, 32'h0000_000F);
    rd("sticky", OFF_STICKY, 32'h0000_000A);
    wr(OFF_CLR_EN, 32'h0000_0002);
    wr(OFF_STICKY, 32'h0000_000F);
    rd("sticky", OFF_STICKY, 32'h0000_0008);
    wr(OFF_IRQ_EN, 32'h0000_0002);
    rd("request", OFF_IRQ_REQ, 32'h0000_0000);
    chk("irq pins", 32'h0000_0000, {28'h000_0000, irq});
    wr(OFF_IRQ_EN, 32'h0000_0008);
    rd("request", OFF_IRQ_REQ, 32'h0000_0008);
    wr(OFF_CLR_EN, 32'h0000_000F);
    wr(OFF_STICKY, 32'h0000_000F);
    rd("sticky", OFF_STICKY, 32'h0000_0000);
    tx_words(1'b0, 32'h0000_00A5, 32'h0000_003C, 2);
    wr(OFF_CONTROL, 32'h0000_0020);
    tx_words(1'b1, 32'h0000_1234, 32'h0000_F00F, 2);
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom;
      u = rnd[0];
      wr(OFF_CONTROL, u ? 32'h0000_0020 : 32'h0000_0000);
      tx_words(u, $urandom, 32'h0000_0000, 1);
    end
    wr(OFF_IRQ_EN, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0200);
    tx_words(1'b0, 32'h0000_005A, 32'h0000_0000, 1);
    chk("tx dma pulses", 32'h1, n_dtx);
    wr(OFF_CONTROL, 32'h0000_0021);
    wait_flags(4'h1, 4'h1);
    rd("rx unit16", OFF_RX_DATA, exp_rx(1'b1));
    wait_flags(4'h1, 4'h1);
    wr(OFF_CONTROL, 32'h0000_0020);
    rd("rx unit16", OFF_RX_DATA, exp_rx(1'b1));
    repeat (300) @(posedge clk_in);
    rd("flags", OFF_FLAGS, 32'h0000_000A);
    wr(OFF_CONTROL, 32'h0000_0001);
    wait_flags(4'h1, 4'h1);
    wr(OFF_CONTROL, 32'h0000_0000);
    rd("rx unit8", OFF_RX_DATA, exp_rx(1'b0));
    rnd = u_per.nbits;
    wr(OFF_CONTROL, 32'h0000_0102);
    wait_flags(4'h5, 4'h5);
    repeat (200) @(posedge clk_in);
    rd("flags", OFF_FLAGS, 32'h0000_000F);
    chk("seq bits", rnd + 32'h0000_0010, u_per.nbits);
    chk("rx dma pulses", 32'h1, n_drx);
    wr(OFF_CONTROL, 32'h0000_0000);
    rd("rx seq", OFF_RX_DATA, exp_rx(1'b0));
    rd("rx seq", OFF_RX_DATA, exp_rx(1'b0));
    rd("flags", OFF_FLAGS, 32'h0000_000A);
    close_out();
  end
endmodule
`default_nettype wire
